// file: rtl/lpoc_defs.svh
`ifndef LPOC_DEFS_SVH
`define LPOC_DEFS_SVH

`define LPOC_MODE_ADDR      8'h01
`define LPOC_PWM_FIRST      8'h06
`define LPOC_PWM_LAST       8'h45
`define LPOC_BIT_INVERT     4
`define LPOC_BIT_UPDATE_ACK 3
`define LPOC_BIT_TOTEM      2
`define LPOC_BIT_DIS_HI     1
`define LPOC_BIT_DIS_LO     0
`define LPOC_MODE_RESET     8'h04
`define LPOC_MODE_WMASK     8'h1F
`define LPOC_HIGH_MASK      8'h0F
`define LPOC_CHAN_BYTES     4
`define LPOC_CHANNELS       16
`define LPOC_CNT_WIDTH      12
`define LPOC_TICK_DIV       1

`endif

// file: rtl/lpoc_pkg.sv
`include "lpoc_defs.svh"

package lpoc_pkg;

  typedef logic [`LPOC_CNT_WIDTH-1:0] lpoc_count_t;
  typedef logic [7:0]                 lpoc_byte_t;

  typedef enum logic {
    LPOC_DRV_OPEN_DRAIN,
    LPOC_DRV_TOTEM
  } lpoc_drive_t;

  // Address falls inside the staged count registers
  function automatic logic lpoc_in_pwm(input lpoc_byte_t addr);
    return (addr >= `LPOC_PWM_FIRST) && (addr <= `LPOC_PWM_LAST);
  endfunction

  // Byte index inside the staged block
  function automatic logic [5:0] lpoc_pwm_index(input lpoc_byte_t addr);
    lpoc_byte_t diff;
    diff = addr - `LPOC_PWM_FIRST;
    return diff[5:0];
  endfunction

endpackage

// file: rtl/lpoc_channel.sv
module lpoc_channel
  import lpoc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        tick_in,
  input  wire lpoc_count_t count_in,
  input  wire lpoc_count_t turn_on_count_in,
  input  wire lpoc_count_t turn_off_count_in,
  output logic             pwm_out
);

  logic pwm_q;

  // Level holds between matches, so an off count below the on count
  // naturally lands in the following frame
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pwm_q <= 1'b0;
    end else if (tick_in) begin
      if (count_in == turn_off_count_in) begin
        pwm_q <= 1'b0;
      end else if (count_in == turn_on_count_in) begin
        pwm_q <= 1'b1;
      end
    end
  end

  assign pwm_out = pwm_q;

endmodule

// file: rtl/lpoc_top.sv
// Operation
// - Enabled outputs follow PWM, optionally inverted
// - Stop mode holds new values until STOP
// - Ack mode applies values on acknowledge
// - Ack mode: channel changes after fourth write
// - STOP applies all staged count registers together
// - Drive bit selects open-drain or totem-pole
// - Disabled, field 00: outputs low
// - Disabled, field 01: high or floating
// - Disabled, field 1x: outputs floating
// - Two 12-bit counts per channel
// - One free-running 12-bit counter wraps
// - Match on asserts, match off negates
// - Off below on negates next frame
// - Outputs low after reset
// - STOP after count write clears restart
// - Stopped oscillator freezes all PWM activity
`include "lpoc_defs.svh"

module lpoc_top
  import lpoc_pkg::*;
#(
  parameter int unsigned TICK_DIV = `LPOC_TICK_DIV
)(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        write_in,
  input  wire lpoc_byte_t  addr_in,
  input  wire lpoc_byte_t  wdata_in,
  input  wire logic        stop_in,
  input  wire logic        osc_enable_in,
  input  wire logic        output_enable_n_in,
  output lpoc_byte_t       rdata_out,
  output logic             restart_clear_out,
  output logic [15:0]      led_channel_output_out,
  output logic [15:0]      led_drive_n_out
);

  localparam int NBYTES = `LPOC_CHANNELS * `LPOC_CHAN_BYTES;

  lpoc_byte_t  mode_q;
  lpoc_byte_t  stage_q [NBYTES];
  lpoc_byte_t  live_q  [NBYTES];
  logic [3:0]  loaded_q [`LPOC_CHANNELS];
  logic        pending_q;
  logic        oe_meta_q;
  logic        oe_n_q;
  logic [15:0] div_q;
  logic        tick;
  lpoc_count_t count_q;
  logic [15:0] pwm;
  logic [15:0] level;
  logic        pwm_wr;
  logic [5:0]  widx;
  logic [3:0]  wchan;
  logic        chan_done;
  logic        stop_apply;
  logic        ack_mode;
  logic        totem;

  assign pwm_wr     = write_in && lpoc_in_pwm(addr_in);
  assign widx       = lpoc_pwm_index(addr_in);
  assign wchan      = widx[5:2];
  assign ack_mode   = mode_q[`LPOC_BIT_UPDATE_ACK];
  assign totem      = (mode_q[`LPOC_BIT_TOTEM] == LPOC_DRV_TOTEM);
  assign chan_done  = pwm_wr && ack_mode && ((loaded_q[wchan] | (4'h1 << widx[1:0])) == 4'hF);
  assign stop_apply = stop_in && pending_q && !ack_mode;

  ////////////////////////////////////////////////////////////////
  // Mode register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mode_q <= `LPOC_MODE_RESET;
    end else if (write_in && addr_in == `LPOC_MODE_ADDR) begin
      mode_q <= wdata_in & `LPOC_MODE_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Staged counts, written byte by byte
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      for (int i = 0; i < NBYTES; i++) begin
        stage_q[i] <= 8'h00;
      end
    end else if (pwm_wr) begin
      stage_q[widx] <= widx[0] ? (wdata_in & `LPOC_HIGH_MASK) : wdata_in;
    end
  end

  // A write landing with STOP keeps the flag, so nothing is lost
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pending_q <= 1'b0;
    end else if (pwm_wr && !ack_mode) begin
      pending_q <= 1'b1;
    end else if (stop_in) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      for (int c = 0; c < `LPOC_CHANNELS; c++) begin
        loaded_q[c] <= 4'h0;
      end
    end else if (pwm_wr && ack_mode) begin
      loaded_q[wchan] <= chan_done ? 4'h0 : (loaded_q[wchan] | (4'h1 << widx[1:0]));
    end
  end

  ////////////////////////////////////////////////////////////////
  // Live counts seen by the comparators
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      for (int i = 0; i < NBYTES; i++) begin
        live_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NBYTES; i++) begin
        if (stop_apply || (chan_done && i[5:2] == wchan)) begin
          if (pwm_wr && widx == i[5:0]) begin
            live_q[i] <= widx[0] ? (wdata_in & `LPOC_HIGH_MASK) : wdata_in;
          end else begin
            live_q[i] <= stage_q[i];
          end
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      restart_clear_out <= 1'b0;
    end else begin
      restart_clear_out <= stop_apply || chan_done;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (addr_in == `LPOC_MODE_ADDR) begin
      rdata_out <= mode_q;
    end else if (lpoc_in_pwm(addr_in)) begin
      rdata_out <= stage_q[widx];
    end else begin
      rdata_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Count rate divider and frame counter
  always_ff @(posedge clock_in) begin
    if (reset_in || !osc_enable_in || div_q == 16'(TICK_DIV - 1)) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  assign tick = osc_enable_in && (div_q == 16'h0000);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      count_q <= 12'h000;
    end else if (tick) begin
      count_q <= count_q + 12'h001;
    end
  end

  for (genvar c = 0; c < `LPOC_CHANNELS; c++) begin : g_chan
    lpoc_channel u_chan (
      .clock_in          (clock_in),
      .reset_in          (reset_in),
      .tick_in           (tick),
      .count_in          (count_q),
      .turn_on_count_in  ({live_q[4*c+1][3:0], live_q[4*c]}),
      .turn_off_count_in ({live_q[4*c+3][3:0], live_q[4*c+2]}),
      .pwm_out           (pwm[c])
    );
  end

  ////////////////////////////////////////////////////////////////
  // Output stage; enable pin is asynchronous, hence two stages
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      oe_meta_q <= 1'b0;
      oe_n_q    <= 1'b0;
    end else begin
      oe_meta_q <= output_enable_n_in;
      oe_n_q    <= oe_meta_q;
    end
  end

  assign level = pwm ^ {16{mode_q[`LPOC_BIT_INVERT]}};

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      led_channel_output_out <= 16'h0000;
      led_drive_n_out        <= 16'h0000;
    end else if (!oe_n_q) begin
      led_channel_output_out <= totem ? level : 16'h0000;
      led_drive_n_out        <= totem ? 16'h0000 : level; // Open drain only sinks
    end else if (mode_q[`LPOC_BIT_DIS_HI]) begin
      led_channel_output_out <= 16'h0000;
      led_drive_n_out        <= 16'hFFFF;
    end else if (mode_q[`LPOC_BIT_DIS_LO]) begin
      led_channel_output_out <= totem ? 16'hFFFF : 16'h0000;
      led_drive_n_out        <= totem ? 16'h0000 : 16'hFFFF;
    end else begin
      led_channel_output_out <= 16'h0000;
      led_drive_n_out        <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_disabled;
    oe_n_q && !mode_q[`LPOC_BIT_DIS_HI];
  endsequence

  property p_invert;
    !oe_n_q && totem |=> led_channel_output_out == $past(level) && led_drive_n_out == 16'h0000;
  endproperty
  a_invert: assert property (p_invert) else $error("enabled output not PWM level");

  property p_stop_hold;
    pwm_wr && !ack_mode && !stop_in |=> live_q[$past(widx)] == $past(live_q[widx]);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("staged value leaked before STOP");

  property p_stop_apply;
    stop_apply && !write_in |=> live_q[0] == $past(stage_q[0]) && live_q[63] == $past(stage_q[63]);
  endproperty
  a_stop_apply: assert property (p_stop_apply) else $error("STOP did not apply staged values");

  property p_ack_apply;
    chan_done |=> live_q[$past(widx)] == $past(stage_q[widx] & 8'h00 | (widx[0] ? wdata_in & 8'h0F : wdata_in));
  endproperty
  a_ack_apply: assert property (p_ack_apply) else $error("ack update not applied");

  property p_ack_wait;
    pwm_wr && ack_mode && !chan_done |=> live_q[$past(widx)] == $past(live_q[widx]);
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("channel changed before fourth write");

  property p_dis_low;
    s_disabled ##0 !mode_q[`LPOC_BIT_DIS_LO] |=> led_channel_output_out == 16'h0000 && led_drive_n_out == 16'h0000;
  endproperty
  a_dis_low: assert property (p_dis_low) else $error("disabled outputs not low");

  property p_dis_high;
    s_disabled ##0 mode_q[`LPOC_BIT_DIS_LO] |=> led_drive_n_out == ($past(totem) ? 16'h0000 : 16'hFFFF);
  endproperty
  a_dis_high: assert property (p_dis_high) else $error("disabled 01 drive wrong");

  property p_dis_float;
    oe_n_q && mode_q[`LPOC_BIT_DIS_HI] |=> led_drive_n_out == 16'hFFFF;
  endproperty
  a_dis_float: assert property (p_dis_float) else $error("disabled 1x outputs driven");

  property p_count;
    tick |=> count_q == $past(count_q) + 12'h001;
  endproperty
  a_count: assert property (p_count) else $error("counter did not advance");

  property p_freeze;
    !osc_enable_in [*2] |=> $stable(count_q) && $stable(pwm);
  endproperty
  a_freeze: assert property (p_freeze) else $error("activity with oscillator stopped");

  property p_restart;
    stop_apply |=> restart_clear_out ##1 (!restart_clear_out || $past(stop_apply || chan_done));
  endproperty
  a_restart: assert property (p_restart) else $error("restart clear pulse missing");

  property p_mode_upper;
    mode_q[7:5] == 3'b000;
  endproperty
  a_mode_upper: assert property (p_mode_upper) else $error("upper mode bits not zero");

endmodule

// file: dv/lpoc_host_model.sv
`include "lpoc_defs.svh"

module lpoc_host_model
  import lpoc_pkg::*;
(
  input  wire logic       clock_in,
  input  wire lpoc_byte_t rdata_in,
  output logic            write_out,
  output lpoc_byte_t      addr_out,
  output lpoc_byte_t      wdata_out,
  output logic            stop_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    write_out = 1'b0;
    stop_out  = 1'b0;
    addr_out  = 8'h00;
    wdata_out = 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  // Released lines show the inverse so stale data cannot pass
  task automatic wr(input lpoc_byte_t a, input lpoc_byte_t d);
    @(negedge clock_in);
    write_out = 1'b1;
    addr_out  = a;
    wdata_out = d;
    @(negedge clock_in);
    write_out = 1'b0;
    addr_out  = ~a;
    wdata_out = ~d;
  endtask

  // Whole channel; counts past the frame come already reduced by 4096
  task automatic wr_chan(input int ch, input lpoc_count_t on, input lpoc_count_t off);
    lpoc_byte_t b;
    b = `LPOC_PWM_FIRST + lpoc_byte_t'(4 * ch);
    wr(b, on[7:0]);
    wr(b + 8'h01, {4'h0, on[11:8]});
    wr(b + 8'h02, off[7:0]);
    wr(b + 8'h03, {4'h0, off[11:8]});
  endtask

  task automatic stop_bus();
    @(negedge clock_in);
    stop_out = 1'b1;
    @(negedge clock_in);
    stop_out = 1'b0;
  endtask

  task automatic rd(input lpoc_byte_t a, output lpoc_byte_t d);
    @(negedge clock_in);
    addr_out = a;
    @(negedge clock_in);
    d = rdata_in;
  endtask
endmodule

// file: dv/tb_led_pwm_output_control.sv
`include "lpoc_defs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end

module tb_led_pwm_output_control
  import lpoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock_in      = 1'b0;
  logic        reset_in      = 1'b1;
  logic        osc_enable_in = 1'b1;
  logic        oe_n          = 1'b0;
  logic        write_in;
  logic        stop_in;
  logic        restart_clear_out;
  lpoc_byte_t  addr_in;
  lpoc_byte_t  wdata_in;
  lpoc_byte_t  rdata_out;
  logic [15:0] led_out;
  logic [15:0] drv_n;
  int          n_errors;
  int          samples_checked;
  int          pulses;
  int          hi[16];

  always #4 clock_in = ~clock_in;

  lpoc_top #(.TICK_DIV(1)) DUT (
    .clock_in               (clock_in),
    .reset_in               (reset_in),
    .write_in               (write_in),
    .addr_in                (addr_in),
    .wdata_in               (wdata_in),
    .stop_in                (stop_in),
    .osc_enable_in          (osc_enable_in),
    .output_enable_n_in     (oe_n),
    .rdata_out              (rdata_out),
    .restart_clear_out      (restart_clear_out),
    .led_channel_output_out (led_out),
    .led_drive_n_out        (drv_n)
  );

  lpoc_host_model host (
    .clock_in  (clock_in),
    .rdata_in  (rdata_out),
    .write_out (write_in),
    .addr_out  (addr_in),
    .wdata_out (wdata_in),
    .stop_out  (stop_in)
  );

  ////////////////////////////////////////////////////////////////
  // Pin seen through a pull-up, so open-drain and totem count alike
  task automatic measure(input int settle);
    repeat (settle) @(negedge clock_in);
    hi = '{default: 0};
    repeat (4096) begin
      @(negedge clock_in);
      foreach (hi[i]) hi[i] += int'(drv_n[i] === 1'b1 || led_out[i] === 1'b1);
    end
  endtask

  task automatic pulse_watch();
    pulses = 0;
    repeat (6) begin
      @(negedge clock_in);
      pulses += int'(restart_clear_out === 1'b1);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    lpoc_byte_t d;
    `CHK("led", 16'h0000, led_out)
    `CHK("drv_n", 16'h0000, drv_n)
    host.rd(`LPOC_MODE_ADDR, d);
    `CHK("mode", `LPOC_MODE_RESET, d)
    host.wr(`LPOC_MODE_ADDR, 8'hFF);
    host.rd(`LPOC_MODE_ADDR, d);
    `CHK("mode ro", 8'h1F, d)
    host.wr(`LPOC_MODE_ADDR, 8'h04);
    $display("test reset done");
  endtask

  task automatic t_stop();
    host.wr_chan(0, 12'h199, 12'h4CC);
    host.wr_chan(4, 12'hE65, 12'hCCB);
    measure(0);
    `CHK("held ch0", 0, hi[0])
    fork
      host.stop_bus();
      pulse_watch();
    join
    `CHK("restart", 1, pulses)
    measure(4100);
    `CHK("ch0", 'h4CC - 'h199, hi[0])
    `CHK("ch4", 4096 - 'hE65 + 'hCCB, hi[4])
    `CHK("ch1", 0, hi[1])
    $display("test stop done");
  endtask

  task automatic t_ack();
    lpoc_byte_t d;
    host.wr(`LPOC_MODE_ADDR, 8'h0C);
    host.wr(8'h0A, 8'h00);
    host.wr(8'h0B, 8'h00);
    host.wr(8'h0C, 8'h00);
    measure(0);
    `CHK("partial ch1", 0, hi[1])
    fork
      host.wr(8'h0D, 8'h01);
      pulse_watch();
    join
    `CHK("ack pulse", 1, pulses)
    measure(4100);
    `CHK("ack ch1", 'h100, hi[1])
    host.wr(8'h0F, 8'hF3);
    host.rd(8'h0F, d);
    `CHK("high byte", 8'h03, d)
    $display("test ack done");
  endtask

  task automatic t_invert_od();
    host.wr(`LPOC_MODE_ADDR, 8'h1C);
    measure(8);
    `CHK("inv ch0", 4096 - 819, hi[0])
    `CHK("inv ch2", 4096, hi[2])
    host.wr(`LPOC_MODE_ADDR, 8'h08);
    measure(8);
    `CHK("od ch1", 'h100, hi[1])
    `CHK("od out", 16'h0000, led_out)
    $display("test invert done");
  endtask

  // Field 01 floats in open-drain, so only drive is judged there
  task automatic t_disabled();
    lpoc_byte_t  dm[5] = '{8'h04, 8'h05, 8'h01, 8'h02, 8'h07};
    logic [15:0] dd[5] = '{16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    @(negedge clock_in);
    oe_n = 1'b1;
    foreach (dm[i]) begin
      host.wr(`LPOC_MODE_ADDR, dm[i]);
      repeat (4) @(negedge clock_in);
      `CHK("dis drv_n", dd[i], drv_n)
      if (i < 2) `CHK("dis out", (i == 1) ? 16'hFFFF : 16'h0000, led_out)
    end
    oe_n = 1'b0;
    $display("test disabled done");
  endtask

  task automatic t_osc();
    logic [15:0] s;
    host.wr(`LPOC_MODE_ADDR, 8'h0C);
    osc_enable_in = 1'b0;
    repeat (4) @(negedge clock_in);
    s = led_out;
    measure(0);
    `CHK("frozen", s, led_out)
    `CHK("frozen ch0", s[0] ? 4096 : 0, hi[0])
    `CHK("frozen ch4", s[4] ? 4096 : 0, hi[4])
    osc_enable_in = 1'b1;
    $display("test osc done");
  endtask

  initial begin
    repeat (8) @(negedge clock_in);
    reset_in = 1'b0;
    t_reset();
    t_stop();
    t_ack();
    t_invert_od();
    t_disabled();
    t_osc();
    end_sim();
  end

  // Tests need about 37k cycles
  initial begin
    #(60000 * 8);
    n_errors++;
    end_sim();
  end
endmodule
